/* inc/hnf_pkg.sv */
// Function
// - Program pages of a block in ascending order (code checks this for 10h only, not for 15h)
// - Five address cycles, two column, three row
// - Poll first die with F1h until ready
// - Poll second die with F2h until ready
// - No plain 70h status while interleaving
// - Mask unused status bits
// - Command latched on write strobe rise, cmd latch
// - Data strobe low during 85h, 10h, 11h
// - Address latched on write strobe rise, addr latch
// - Data-in condition held through strobe burst
// - Data strobe steady before data-in condition
// - Bursts move an even number of bytes
// - Data-out condition held through read strobe burst
// - Read strobe steady before data-out condition
// - Latest failed block recorded; program and erase to it refused (code does this for 10h and D0h only; a 15h is neither recorded nor refused)
package hnf_pkg;
    // ------------------------------------------------
    // Register map and fields
    // ------------------------------------------------
    localparam logic [7:0] REG_CMD     = 8'h00;
    localparam logic [7:0] REG_STAT    = 8'h04;
    localparam logic [7:0] REG_RDATA   = 8'h08;
    localparam logic [7:0] REG_DIESTAT = 8'h0c;
    localparam logic [7:0] REG_BAD     = 8'h10;
    localparam int         BAD_VALID   = 31;
    localparam int         PAGE_W_DEF  = 8;
    // ------------------------------------------------
    // Flash command codes and status bits
    // ------------------------------------------------
    localparam logic [7:0] CMD_STATUS  = 8'h70;
    localparam logic [7:0] CMD_POLL1   = 8'hf1;
    localparam logic [7:0] CMD_POLL2   = 8'hf2;
    localparam logic [7:0] CMD_PROG    = 8'h10;
    localparam logic [7:0] CMD_ERASE   = 8'hd0;
    localparam logic [7:0] CMD_CBPROG  = 8'h15;
    localparam logic [7:0] CMD_READ    = 8'h30;
    localparam logic [7:0] CMD_CBREAD  = 8'h35;
    localparam int         BIT_FAIL    = 0;
    localparam int         BIT_RDY     = 6;
    localparam logic [7:0] STAT_MASK   = 8'hc7;
    localparam logic [2:0] ROW_FIRST   = 3'h2;
    // ------------------------------------------------
    // Timing
    // ------------------------------------------------
    localparam int         CLK_NS      = 50;
    localparam int         T_WHR_NS    = 120;
    localparam int         T_ADL_NS    = 300;
    localparam logic [3:0] WHR_CYC     = 4'((T_WHR_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] ADL_CYC     = 4'((T_ADL_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] GAP_MIN     = 4'h1;
    localparam logic [3:0] RPRE_CYC    = 4'h3; // Strobe sync depth plus one
    // ------------------------------------------------
    // Types
    // ------------------------------------------------
    typedef enum logic [2:0] {K_CMD, K_ADDR, K_WR, K_RD, K_POLL} hnf_kind_t;
    typedef struct packed {
        logic [11:0] rsvd;
        logic        die;
        hnf_kind_t   kind;
        logic [7:0]  b1;
        logic [7:0]  b0;
    } hnf_cmd_t;
    typedef struct packed {
        logic       ceN;
        logic       cmdLatch;
        logic       addrLatch;
        logic       weN;
        logic       readStrobeN;
        logic       dqsOut;
        logic       dqsOe;
        logic       dqOe;
        logic [7:0] dq;
    } hnf_pins_t;
    localparam hnf_pins_t PINS_IDLE = '{ceN: 1'b1, cmdLatch: 1'b0, addrLatch: 1'b0, weN: 1'b1,
        readStrobeN: 1'b1, dqsOut: 1'b0, dqsOe: 1'b1, dqOe: 1'b0, dq: 8'h00};
endpackage

/* src/hnf_host_ctrl.sv */
`timescale 1ns/100ps
module hnf_host_ctrl #(
    parameter int PAGE_W = hnf_pkg::PAGE_W_DEF
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [7:0]        dqIn,
    input  wire logic              dqsIn,
    output hnf_pkg::hnf_pins_t     pins
);
    typedef enum logic [3:0] {
        S_IDLE, S_WHI, S_GAP, S_WPRE, S_WB0, S_WB1, S_WPST, S_RPRE, S_RTOG, S_RWAIT, S_RPST, S_REND
    } hnf_state_t;

    hnf_state_t           state;
    hnf_pkg::hnf_kind_t   op;
    logic                 opDie;
    logic [7:0]           b1;
    logic [3:0]           gap;
    logic                 rdIdx;
    logic [15:0]          rdBuf;
    logic [7:0]           dqS1, dqS2;
    logic                 dqsS1, dqsS2, dqsPrev;
    logic [1:0]           dieBusy, dieWrite, lastValid;
    logic [7:0]           dieStat [2];
    logic [23:0]          lastRow [2];
    logic [23:0]          opRow [2];
    logic [23:0]          rowAddr, badBlock;
    logic                 badValid;
    logic [2:0]           addrIdx;
    logic                 refFlag, orderFlag, failFlag;

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    function automatic logic [23:0] blockOf(input logic [23:0] r);
        return r >> PAGE_W;
    endfunction

    function automatic logic [PAGE_W-1:0] pageOf(input logic [23:0] r);
        return r[PAGE_W-1:0];
    endfunction

    // Codes that start an array operation and leave the die busy
    function automatic logic isConfirm(input logic [7:0] c);
        return c == hnf_pkg::CMD_PROG || c == hnf_pkg::CMD_ERASE || c == hnf_pkg::CMD_CBPROG
            || c == hnf_pkg::CMD_READ || c == hnf_pkg::CMD_CBREAD;
    endfunction

    // ------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------
    // Strobe and data from the flash are asynchronous; both get the same delay
    always_ff @(posedge clk) begin
        dqS1  <= dqIn;
        dqS2  <= dqS1;
        dqsS1 <= dqsIn;
        dqsS2 <= dqsS1;
    end

    // ------------------------------------------------
    // Bus decode and order checks
    // ------------------------------------------------
    // Order word as software wrote it
    // Fields: byte 0, byte 1, kind and die
    hnf_pkg::hnf_cmd_t cw;
    wire busReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wrCmd   = busReq & wb_we_i & (wb_adr_i == hnf_pkg::REG_CMD) & (&wb_sel_i);
    wire wrStat  = busReq & wb_we_i & (wb_adr_i == hnf_pkg::REG_STAT) & wb_sel_i[0];
    wire wrBad   = busReq & wb_we_i & (wb_adr_i == hnf_pkg::REG_BAD) & (&wb_sel_i);
    assign cw    = hnf_pkg::hnf_cmd_t'(wb_dat_i);
    wire isCmd   = cw.kind == hnf_pkg::K_CMD;
    wire kindOk  = cw.kind inside {hnf_pkg::K_CMD, hnf_pkg::K_ADDR, hnf_pkg::K_WR, hnf_pkg::K_RD,
                                   hnf_pkg::K_POLL};
    // Refusal keeps the flash legal even when software is not
    // A refused order only sets a flag; the bus never stalls
    wire blkBad  = badValid & (blockOf(rowAddr) == badBlock);
    wire sameBlk = blockOf(rowAddr) == blockOf(lastRow[cw.die]);
    wire orderBad = lastValid[cw.die] & sameBlk & (pageOf(rowAddr) <= pageOf(lastRow[cw.die]));
    wire progBad = isCmd & (cw.b0 == hnf_pkg::CMD_PROG) & (orderBad | blkBad);
    wire eraseBad = isCmd & (cw.b0 == hnf_pkg::CMD_ERASE) & blkBad;
    wire plainStat = isCmd & (cw.b0 == hnf_pkg::CMD_STATUS) & (|dieBusy);
    wire dieHeld = (cw.kind != hnf_pkg::K_POLL) & dieBusy[cw.die];
    wire refuse  = wrCmd & ((state != S_IDLE) | ~kindOk | dieHeld | plainStat | progBad | eraseBad);
    wire start   = wrCmd & ~refuse;

    // Read path events
    // Edges are seen on the synchronised strobe, two cycles late
    wire dqsEdge  = (state == S_RWAIT) & (dqsS2 != dqsPrev);
    wire pairDone = dqsEdge & rdIdx;
    wire isPoll   = op == hnf_pkg::K_POLL;
    wire pollDone = pairDone & isPoll & dqS2[hnf_pkg::BIT_RDY];
    // Settle time after the write strobe, chosen by order kind
    wire [3:0] gapLen = isPoll ? hnf_pkg::WHR_CYC
                      : (op == hnf_pkg::K_ADDR) ? hnf_pkg::ADL_CYC : hnf_pkg::GAP_MIN;

    // ------------------------------------------------
    // Pin sequencer
    // ------------------------------------------------
    // One bus cycle per order; chip select is dropped between orders
    always_ff @(posedge clk) begin
        if (srst) begin
            state   <= S_IDLE;
            pins    <= hnf_pkg::PINS_IDLE;
            op      <= hnf_pkg::K_CMD;
            opDie   <= 1'b0;
            b1      <= 8'h00;
            gap     <= 4'h0;
            rdIdx   <= 1'b0;
            rdBuf   <= 16'h0000;
            dqsPrev <= 1'b0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (start) begin
                        op       <= cw.kind;
                        opDie    <= cw.die;
                        b1       <= cw.b1;
                        pins.ceN <= 1'b0;
                        unique case (cw.kind)
                            hnf_pkg::K_CMD, hnf_pkg::K_ADDR, hnf_pkg::K_POLL: begin
                                pins.cmdLatch  <= cw.kind != hnf_pkg::K_ADDR;
                                pins.addrLatch <= cw.kind == hnf_pkg::K_ADDR;
                                pins.weN       <= 1'b0;
                                pins.dqOe      <= 1'b1;
                                pins.dq        <= (cw.kind != hnf_pkg::K_POLL) ? cw.b0
                                                : (cw.die ? hnf_pkg::CMD_POLL2 : hnf_pkg::CMD_POLL1);
                                state          <= S_WHI;
                            end
                            // Strobe already held low since idle, so it is steady first
                            hnf_pkg::K_WR: begin
                                pins.dqOe <= 1'b1;
                                pins.dq   <= cw.b0;
                                state     <= S_WPRE;
                            end
                            default: begin
                                pins.dqsOe <= 1'b0;
                                gap        <= hnf_pkg::RPRE_CYC;
                                state      <= S_RPRE;
                            end
                        endcase
                    end
                end
                // Rising write strobe latches; data strobe stays driven low
                S_WHI: begin
                    pins.weN <= 1'b1;
                    gap      <= gapLen;
                    state    <= S_GAP;
                end
                // Latch enables fall one cycle after the strobe for hold time
                S_GAP: begin
                    pins.cmdLatch  <= 1'b0;
                    pins.addrLatch <= 1'b0;
                    if (gap == hnf_pkg::GAP_MIN) begin
                        if (isPoll) begin
                            pins.dqOe  <= 1'b0;
                            gap        <= hnf_pkg::RPRE_CYC;
                            pins.dqsOe <= 1'b0;
                            state      <= S_RPRE;
                        end else begin
                            pins  <= hnf_pkg::PINS_IDLE;
                            state <= S_IDLE;
                        end
                    end else begin
                        gap <= gap - 4'h1;
                    end
                end
                // Write burst: byte 0 on rising, byte 1 on falling strobe
                S_WPRE: begin
                    pins.dqsOut <= 1'b1;
                    state       <= S_WB0;
                end
                // Second byte gets a full cycle of setup before its edge
                S_WB0: begin
                    pins.dq <= b1;
                    state   <= S_WB1;
                end
                // Strobe falls for the second byte, so the burst ends low
                S_WB1: begin
                    pins.dqsOut <= 1'b0;
                    state       <= S_WPST;
                end
                // Postamble, then the pins go back to idle
                S_WPST: begin
                    pins  <= hnf_pkg::PINS_IDLE;
                    state <= S_IDLE;
                end
                // Read preamble: strobe held low for RPRE_CYC cycles, so the synchronised
                // data strobe shows the flash driving it, not the floating bus
                S_RPRE: begin
                    pins.readStrobeN <= 1'b0;
                    if (gap == hnf_pkg::GAP_MIN) begin
                        state <= S_RTOG;
                    end else begin
                        gap <= gap - 4'h1;
                    end
                end
                // Each toggle asks the flash for one more byte
                S_RTOG: begin
                    pins.readStrobeN <= ~pins.readStrobeN;
                    dqsPrev          <= dqsS2;
                    state            <= S_RWAIT;
                end
                // No timeout: a dead flash hangs here, visible as busy
                S_RWAIT: begin
                    if (dqsEdge) begin
                        rdBuf <= {dqS2, rdBuf[15:8]};
                        rdIdx <= ~rdIdx;
                        if (pairDone & ~(isPoll & ~dqS2[hnf_pkg::BIT_RDY])) begin
                            state <= S_RPST;
                        end else begin
                            state <= S_RTOG;
                        end
                    end
                end
                // Postamble: strobe back high before select is dropped
                S_RPST: begin
                    pins.readStrobeN <= 1'b1;
                    state            <= S_REND;
                end
                // Select rises last, so the flash lets go of its drivers
                S_REND: begin
                    pins  <= hnf_pkg::PINS_IDLE;
                    state <= S_IDLE;
                end
                // Illegal state code: fall back to idle pins
                default: begin
                    pins  <= hnf_pkg::PINS_IDLE;
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------
    // Die tracking and address capture
    // ------------------------------------------------
    // Row bytes are the third to fifth address cycles
    always_ff @(posedge clk) begin
        if (srst) begin
            rowAddr <= 24'h000000;
            addrIdx <= 3'h0;
        end else if (start & isCmd) begin
            addrIdx <= 3'h0;
        end else if (start & (cw.kind == hnf_pkg::K_ADDR)) begin
            unique case (addrIdx)
                3'h2: rowAddr[7:0]   <= cw.b0;
                3'h3: rowAddr[15:8]  <= cw.b0;
                3'h4: rowAddr[23:16] <= cw.b0;
                default: ;
            endcase
            if (addrIdx != 3'h5) begin
                addrIdx <= addrIdx + 3'h1;
            end
        end
    end

    // Busy is set by our own confirm and cleared only by a ready poll
    always_ff @(posedge clk) begin
        if (srst) begin
            dieBusy   <= 2'b00;
            dieWrite  <= 2'b00;
            lastValid <= 2'b00;
            dieStat   <= '{8'h00, 8'h00};
            lastRow   <= '{24'h000000, 24'h000000};
            opRow     <= '{24'h000000, 24'h000000};
            badBlock  <= 24'h000000;
            badValid  <= 1'b0;
        end else begin
            if (start & isCmd & isConfirm(cw.b0)) begin
                dieBusy[cw.die]  <= 1'b1;
                dieWrite[cw.die] <= (cw.b0 == hnf_pkg::CMD_PROG) | (cw.b0 == hnf_pkg::CMD_ERASE);
                opRow[cw.die]    <= rowAddr;
                if (cw.b0 == hnf_pkg::CMD_PROG) begin
                    lastRow[cw.die]   <= rowAddr;
                    lastValid[cw.die] <= 1'b1;
                end else if (cw.b0 == hnf_pkg::CMD_ERASE) begin
                    lastValid[cw.die] <= 1'b0;
                end
            end
            // Software may also enter a bad block by hand
            if (wrBad) begin
                badBlock <= wb_dat_i[23:0];
                badValid <= wb_dat_i[hnf_pkg::BAD_VALID];
            end
            // Only a ready answer is trusted; busy bytes carry no result
            if (pollDone) begin
                dieBusy[opDie] <= 1'b0;
                dieStat[opDie] <= dqS2 & hnf_pkg::STAT_MASK;
                if (dqS2[hnf_pkg::BIT_FAIL] & dieWrite[opDie]) begin
                    badBlock <= blockOf(opRow[opDie]);
                    badValid <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------
    // Sticky flags, set wins over clear
    // ------------------------------------------------
    // A failure counts only after program or erase, never after a read
    // Order errors flag only the page order, not a bad-block hit
    wire failSet = pollDone & dqS2[hnf_pkg::BIT_FAIL] & dieWrite[opDie];
    always_ff @(posedge clk) begin
        if (srst) begin
            refFlag   <= 1'b0;
            orderFlag <= 1'b0;
            failFlag  <= 1'b0;
        end else begin
            refFlag   <= (refFlag & ~(wrStat & wb_dat_i[3])) | refuse;
            orderFlag <= (orderFlag & ~(wrStat & wb_dat_i[4])) | (wrCmd & progBad & orderBad);
            failFlag  <= (failFlag & ~(wrStat & wb_dat_i[5])) | failSet;
        end
    end

    // ------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------
    // Unmapped addresses answer with zero, so a bad pointer never stalls the bus
    wire [31:0] rdMux = (wb_adr_i == hnf_pkg::REG_STAT)
                      ? {26'h0, failFlag, orderFlag, refFlag, dieBusy, state != S_IDLE}
                      : (wb_adr_i == hnf_pkg::REG_RDATA) ? {16'h0000, rdBuf}
                      : (wb_adr_i == hnf_pkg::REG_DIESTAT) ? {16'h0000, dieStat[1], dieStat[0]}
                      : (wb_adr_i == hnf_pkg::REG_BAD) ? {badValid, 7'h00, badBlock}
                      : 32'h00000000;

    // Registered answer: ack one cycle after the request is taken
    always_ff @(posedge clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= rdMux;
        end
    end
endmodule

/* verif/hnf_flash_model.sv */
`timescale 1ns/100ps
module hnf_flash_model #(
    parameter int BUSY_CYC = 200
) (
    input  wire logic               clk,
    input  wire hnf_pkg::hnf_pins_t pins,
    input  wire logic [1:0]         failDie,
    output wire logic [7:0]         dqIn,
    output wire logic               dqsIn
);
    // ------------------------------
    // Two dies behind one select
    // ------------------------------
    int         now = 0;
    int         busyEnd [2] = '{0, 0};
    logic [1:0] failed = 2'h0;
    logic       die = 1'h0, sel = 1'h0, stMode = 1'h0;
    logic       outOn = 1'h0, devDqs = 1'h0, reLast = 1'h1, lastDqs = 1'h0;
    logic [7:0] edges = 8'h00, lastDq = 8'h00;
    wire        rdy = now >= busyEnd[sel];
    wire  [7:0] stat = {1'h1, rdy, 3'h7, {3{failed[sel]}}};
    wire  [7:0] outByte = stMode ? stat : 8'h9f + edges;
    // Released lines drift so a stale value is never trusted
    assign dqsIn = pins.dqsOe ? pins.dqsOut : (outOn ? devDqs : ~lastDqs);
    assign dqIn  = pins.dqOe ? pins.dq : (outOn ? outByte : ~lastDq);
    always @(posedge clk) begin
        now <= now + 1;
        lastDq <= dqIn;
        lastDqs <= dqsIn;
    end
    // Bytes land on the write strobe rise; die comes from the top row bit
    always @(posedge pins.weN) begin
        if (!pins.ceN && pins.cmdLatch && !pins.addrLatch) begin
            stMode <= pins.dq inside {8'h70, 8'hf1, 8'hf2};
            if (pins.dq inside {8'hf1, 8'hf2}) sel <= pins.dq[1];
            if (pins.dq inside {8'h10, 8'h15, 8'h30, 8'h35, 8'hd0}) begin
                busyEnd[die] <= now + BUSY_CYC;
                failed[die] <= failDie[die];
            end
        end else if (!pins.ceN && !pins.cmdLatch && pins.addrLatch) begin
            die <= pins.dq[7];
        end
    end
    // Drivers start at the preamble, data on both edges, off on deselect
    always @(pins.readStrobeN or pins.ceN or pins.cmdLatch) begin
        if (pins.ceN || pins.cmdLatch) begin
            outOn = 1'h0;
            edges = 8'h00;
        end else if (!pins.addrLatch && pins.weN && pins.readStrobeN !== reLast) begin
            edges = outOn ? edges + 8'h01 : edges;
            outOn = 1'h1;
            devDqs = pins.readStrobeN;
        end
        reLast = pins.readStrobeN;
    end
endmodule

/* verif/hnf_host_ctrl_sva.sv */
`timescale 1ns/100ps
module hnf_host_ctrl_sva (
    input wire logic               clk,
    input wire logic               srst,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_ack_o,
    input wire hnf_pkg::hnf_pins_t pins
);
    // ------------------------------
    // Bus answer and pin conditions
    // ------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    AST_CMD_LATCH: assert property ($rose(pins.weN) && pins.cmdLatch |-> !pins.ceN && !pins.addrLatch)
        else $error("command strobe out of condition");
    AST_ADDR_LATCH: assert property ($rose(pins.weN) && pins.addrLatch |-> !pins.ceN && !pins.cmdLatch)
        else $error("address strobe out of condition");
    AST_DQS_CMD: assert property (pins.cmdLatch |-> pins.dqsOe && !pins.dqsOut)
        else $error("data strobe not low in command cycle");
    AST_DIN_COND: assert property ($changed(pins.dqsOut) && pins.dqOe |->
        !pins.ceN && !pins.cmdLatch && !pins.addrLatch && pins.weN && pins.readStrobeN)
        else $error("data strobe toggled outside input condition");
    AST_EVEN: assert property ($fell(pins.dqOe) |-> !pins.dqsOut)
        else $error("odd data strobe edges in burst");
    AST_DOUT_COND: assert property (!pins.readStrobeN |->
        !pins.ceN && !pins.cmdLatch && !pins.addrLatch && pins.weN && !pins.dqOe)
        else $error("read strobe low outside output condition");
    AST_RE_STEADY: assert property ($fell(pins.ceN) |-> pins.readStrobeN && $past(pins.readStrobeN))
        else $error("read strobe moving at select");
endmodule
bind hnf_host_ctrl hnf_host_ctrl_sva hnf_host_ctrl_sva_inst (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pins(pins));

/* verif/hnf_host_ctrl_tb.sv */
`timescale 1ns/100ps
module hnf_host_ctrl_tb;
    logic               clk = 1'h0, srst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, dqs;
    logic [7:0]         adr = 8'h00, dq;
    logic [31:0]        wdat = 32'h0, rdat;
    logic [1:0]         failDie = 2'h0;
    hnf_pkg::hnf_pins_t pins;
    int                 failures = 0, total_checks = 0;
    always #25 clk = ~clk;
    hnf_host_ctrl hnf_host_ctrl_inst (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .dqIn(dq),
        .dqsIn(dqs), .pins(pins));
    hnf_flash_model hnf_flash_model_inst (.clk(clk), .pins(pins), .failDie(failDie), .dqIn(dq), .dqsIn(dqs));
    // ------------------------------
    // Bus and sequence tasks
    // ------------------------------
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Request held until ack is sampled; a hang ends the run
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1 && n < 50);
        q = rdat;
        {cyc, stb} <= 2'h0;
        if (n >= 50) begin
            failures++;
            print_verdict();
        end
    endtask
    // Sticky status flags are cleared after each look
    task automatic chk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'h0, a, 32'h0, q);
        check(nm, e, q & m);
        if (a == hnf_pkg::REG_STAT) bus(1'h1, a, 32'h38, q);
    endtask
    task automatic op(input hnf_pkg::hnf_kind_t k, input logic d, input logic [7:0] b0);
        hnf_pkg::hnf_cmd_t c;
        logic [31:0]       q;
        int                n = 0;
        c = '{rsvd: 12'h000, die: d, kind: k, b1: 8'h22, b0: b0};
        bus(1'h1, hnf_pkg::REG_CMD, c, q);
        do begin
            bus(1'h0, hnf_pkg::REG_STAT, 32'h0, q);
            n++;
        end while (q[0] !== 1'h0 && n < 300);
        if (n >= 300) begin
            failures++;
            print_verdict();
        end
    endtask
    task automatic seq(input logic d, input logic [23:0] row, input logic [7:0] c1, input logic [7:0] c2);
        logic [39:0] a = {row, 16'h0000};
        op(hnf_pkg::K_CMD, d, c1);
        for (int i = 0; i < 5; i++) op(hnf_pkg::K_ADDR, d, a[8*i+:8]);
        if (c1 == 8'h80) op(hnf_pkg::K_WR, d, 8'h11);
        op(hnf_pkg::K_CMD, d, c2);
    endtask
    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic scnReset();
        logic [31:0] q;
        bus(1'h1, 8'h20, 32'hffffffff, q);
        for (int a = 4; a <= 32; a += 4) chk("reset value", 8'(a), 32'hffffffff, 32'h0);
    endtask
    task automatic scnInterleave();
        seq(1'h0, 24'h000005, 8'h80, hnf_pkg::CMD_PROG);
        seq(1'h1, 24'h800003, 8'h80, hnf_pkg::CMD_PROG);
        chk("both busy", hnf_pkg::REG_STAT, 32'he, 32'h6);
        op(hnf_pkg::K_CMD, 1'h0, hnf_pkg::CMD_STATUS);
        chk("plain status", hnf_pkg::REG_STAT, 32'h8, 32'h8);
        op(hnf_pkg::K_CMD, 1'h0, 8'h00);
        chk("busy die order", hnf_pkg::REG_STAT, 32'h8, 32'h8);
        op(hnf_pkg::K_POLL, 1'h0, 8'h00);
        chk("first die ready", hnf_pkg::REG_STAT, 32'he, 32'h4);
        op(hnf_pkg::K_CMD, 1'h0, hnf_pkg::CMD_STATUS);
        chk("status while interleaved", hnf_pkg::REG_STAT, 32'h8, 32'h8);
        op(hnf_pkg::K_POLL, 1'h1, 8'h00);
        chk("die status", hnf_pkg::REG_DIESTAT, 32'hffff, 32'hc0c0);
    endtask
    task automatic scnOrderFail();
        seq(1'h0, 24'h000005, 8'h80, hnf_pkg::CMD_PROG);
        chk("page order", hnf_pkg::REG_STAT, 32'h1a, 32'h18);
        failDie <= 2'h2;
        seq(1'h1, 24'h800104, 8'h80, hnf_pkg::CMD_PROG);
        failDie <= 2'h0;
        op(hnf_pkg::K_POLL, 1'h1, 8'h00);
        chk("fail status", hnf_pkg::REG_DIESTAT, 32'hff00, 32'hc700);
        chk("fail flag", hnf_pkg::REG_STAT, 32'h20, 32'h20);
        chk("bad block", hnf_pkg::REG_BAD, 32'hffffffff, 32'h80008001);
        seq(1'h1, 24'h800105, 8'h80, hnf_pkg::CMD_PROG);
        chk("bad block use", hnf_pkg::REG_STAT, 32'h18, 32'h8);
        op(hnf_pkg::K_CMD, 1'h1, hnf_pkg::CMD_ERASE);
        chk("bad block erase", hnf_pkg::REG_STAT, 32'h8, 32'h8);
    endtask
    task automatic scnRead();
        seq(1'h0, 24'h000010, 8'h00, hnf_pkg::CMD_READ);
        chk("read busy", hnf_pkg::REG_STAT, 32'h2, 32'h2);
        op(hnf_pkg::K_POLL, 1'h0, 8'h00);
        op(hnf_pkg::K_RD, 1'h0, 8'h00);
        chk("status repeat", hnf_pkg::REG_RDATA, 32'hffff, 32'hf8f8);
        op(hnf_pkg::K_CMD, 1'h0, 8'h00);
        op(hnf_pkg::K_RD, 1'h0, 8'h00);
        chk("read pair", hnf_pkg::REG_RDATA, 32'hffff, 32'ha1a0);
    endtask
    // Reset, then each scenario in turn
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'h0;
        scnReset();
        scnInterleave();
        scnOrderFail();
        scnRead();
        print_verdict();
    end
endmodule
